// [inc/dmc_pkg.sv]
// shared constants and types for the dma channel setup and interrupt block
package dmc_pkg;

    // ------------------------------------------------------------------
    // register map (byte offsets on the module register port)
    // ------------------------------------------------------------------
    localparam logic [11:0] IRQ_SETUP_OFS = 12'h784;
    localparam logic [11:0] CHANNEL_SETUP_OFS = 12'h788;
    localparam logic [11:0] CHANNEL_STATE_OFS = 12'h78a;

    // ------------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] VECTOR_RESET = 8'h0f;
    localparam logic [2:0] LEVEL_RESET = 3'h0;
    localparam int STATE_SUMMARY_BIT = 15;
    localparam int STATE_DONE_BIT = 14;
    localparam int STATE_RFAULT_BIT = 13;
    localparam int STATE_WFAULT_BIT = 12;
    localparam int STATE_SFAULT_BIT = 11;
    localparam int STATE_BRK_BIT = 10;

    // ------------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] WIDTH_LONG = 2'h0;
    localparam logic [1:0] WIDTH_BYTE = 2'h1;
    localparam logic [1:0] WIDTH_WORD = 2'h2;
    localparam logic [1:0] TRIG_INTERNAL = 2'h0;
    localparam logic [1:0] TRIG_RESERVED = 2'h1;
    localparam logic [1:0] TRIG_EXT_BURST = 2'h2;
    localparam logic [1:0] TRIG_EXT_STEAL = 2'h3;
    localparam logic [2:0] STEP_LONG = 3'h4;
    localparam logic [2:0] STEP_WORD = 3'h2;
    localparam logic [2:0] STEP_BYTE = 3'h1;
    localparam logic [2:0] STEP_NONE = 3'h0;

    // bandwidth window: 1024 clocks, share granted in quarters of 256
    localparam int BW_WINDOW_CLKS = 1024;
    localparam int BW_CNT_W = 10;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic breakpoint_irq_enable;
        logic done_irq_enable;
        logic error_irq_enable;
        logic external_handshake_option;
        logic src_pointer_step;
        logic dst_pointer_step;
        logic [1:0] read_width_select;
        logic [1:0] write_width_select;
        logic [1:0] transfer_trigger;
        logic [1:0] bandwidth_share;
        logic single_address;
        logic channel_go;
    } dmc_setup_t;

    typedef struct packed {
        logic done;
        logic read_fault;
        logic write_fault;
        logic setup_fault;
        logic breakpoint;
    } dmc_flags_t;

    typedef enum logic [2:0] {
        CH_IDLE = 3'b001,
        CH_ARMED = 3'b010,
        CH_RUN = 3'b100
    } dmc_state_t;

endpackage : dmc_pkg

// [design/dmc_channel.sv]
// dma channel setup register, interrupt setup register and channel start control
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] irq setup: supervisor access only, halt clear
// [RULE_02] irq level driven onto request line
// [RULE_03] 8-bit vector, resets to 0x0f
// [RULE_04] channel setup: any privilege, halt clear
// [RULE_05] breakpoint enable sets flag; AND requests
// [RULE_06] done enable plus done flag requests
// [RULE_07] error enable plus any fault requests
// [RULE_08] handshake option ignored in internal mode
// [RULE_09] single mode: option picks read/write phase
// [RULE_10] dual mode: option picks requesting side
// [RULE_11] source pointer steps 1/2/4 or holds
// [RULE_12] destination pointer steps by source size
// [RULE_13] bits 9:8 select read cycle width
// [RULE_14] bits 7:6 select write cycle width
// [RULE_15] bits 5:4 select request mode
// [RULE_16] internal bandwidth share per 1024 clocks
// [RULE_17] single/dual address select, holding register
// [RULE_18] go clears on reset, zero, flags
// [RULE_19] go set ignored while summary set
// [RULE_20] internal mode runs while go set
// [RULE_21] external mode: go arms, demand starts
// [RULE_22] setup writes take effect immediately
// [RULE_23] halt set: register access gets bus error
// [RULE_24] summary flag is OR of flags
// [RULE_25] reset clears go, keeps other setup
module dmc_channel (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // register port
    input wire logic reg_sel_i,
    input wire logic reg_wr_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [1:0] reg_be_i,
    input wire logic reg_sup_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_ack_o,
    output logic reg_berr_o,
    // module control
    input wire logic module_halt_bit_i,
    // transfer engine events
    input wire logic done_evt_i,
    input wire logic read_fault_evt_i,
    input wire logic write_fault_evt_i,
    input wire logic setup_fault_evt_i,
    input wire logic breakpoint_evt_i,
    // external handshake pins
    input wire logic ext_transfer_demand_i,
    output logic ext_transfer_grant_o,
    // transfer engine control
    output logic bus_request_o,
    output logic hs_read_phase_o,
    output logic single_address_o,
    output logic dst_hold_used_o,
    output logic [1:0] read_width_o,
    output logic [1:0] write_width_o,
    output logic [2:0] src_step_o,
    output logic [2:0] dst_step_o,
    // interrupt request toward the core
    output logic irq_req_o,
    output logic [2:0] irq_level_o,
    output logic [7:0] irq_vector_o
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    dmc_pkg::dmc_setup_t setup_r;
    dmc_pkg::dmc_flags_t flags_r;
    dmc_pkg::dmc_flags_t flag_set;
    dmc_pkg::dmc_state_t state_r;
    dmc_pkg::dmc_state_t state_nxt;
    logic [2:0] level_r;
    logic [7:0] vector_r;
    logic demand_meta_r;
    logic demand_sync_r;
    logic [dmc_pkg::BW_CNT_W-1:0] bw_cnt_r;
    logic summary;
    logic acc_setup;
    logic acc_irq;
    logic acc_state;
    logic acc_ok;
    logic wr_setup_hi;
    logic wr_setup_lo;
    logic wr_irq_hi;
    logic wr_irq_lo;
    logic wr_state_hi;
    logic ext_mode;
    logic bw_open;
    logic [2:0] src_size_step;

    // ------------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------------
    assign acc_irq = reg_sel_i && (reg_addr_i == dmc_pkg::IRQ_SETUP_OFS);
    assign acc_setup = reg_sel_i && (reg_addr_i == dmc_pkg::CHANNEL_SETUP_OFS);
    assign acc_state = reg_sel_i && (reg_addr_i == dmc_pkg::CHANNEL_STATE_OFS);
    // halted module answers nothing but bus errors; user code may not touch irq setup
    assign acc_ok = !module_halt_bit_i && !(acc_irq && !reg_sup_i); // [RULE_23] [RULE_01]
    assign wr_irq_hi = acc_irq && acc_ok && reg_wr_i && reg_be_i[1]; // [RULE_01]
    assign wr_irq_lo = acc_irq && acc_ok && reg_wr_i && reg_be_i[0];
    assign wr_setup_hi = acc_setup && acc_ok && reg_wr_i && reg_be_i[1]; // [RULE_04]
    assign wr_setup_lo = acc_setup && acc_ok && reg_wr_i && reg_be_i[0];
    assign wr_state_hi = acc_state && acc_ok && reg_wr_i && reg_be_i[1];

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            reg_ack_o <= 1'b0;
            reg_berr_o <= 1'b0;
            reg_rdata_o <= 16'h0000;
        end else begin
            reg_ack_o <= reg_sel_i && acc_ok;
            reg_berr_o <= reg_sel_i && !acc_ok; // [RULE_23]
            reg_rdata_o <= 16'h0000;
            if (reg_sel_i && acc_ok && !reg_wr_i) begin
                if (acc_irq) begin
                    reg_rdata_o <= {5'h00, level_r, vector_r};
                end else if (acc_setup) begin
                    reg_rdata_o <= setup_r;
                end else if (acc_state) begin
                    reg_rdata_o <= {summary, flags_r, 10'h000};
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt setup register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            level_r <= dmc_pkg::LEVEL_RESET;
            vector_r <= dmc_pkg::VECTOR_RESET; // [RULE_03]
        end else begin
            if (wr_irq_hi) begin
                level_r <= reg_wdata_i[10:8];
            end
            if (wr_irq_lo) begin
                vector_r <= reg_wdata_i[7:0]; // [RULE_03]
            end
        end
    end

    // ------------------------------------------------------------------
    // channel setup register
    // ------------------------------------------------------------------
    // fields other than go have no reset: software reprograms them after reset
    always_ff @(posedge clk_i) begin
        if (wr_setup_hi) begin
            setup_r[15:8] <= reg_wdata_i[15:8]; // [RULE_22] [RULE_25]
        end
        if (wr_setup_lo) begin
            setup_r[7:1] <= reg_wdata_i[7:1]; // [RULE_22]
        end
        // go: any new flag or a written zero wins over a written one
        if (!rst_b_i) begin
            setup_r.channel_go <= 1'b0; // [RULE_25] [RULE_18]
        end else if (|flag_set) begin
            setup_r.channel_go <= 1'b0; // [RULE_18]
        end else if (wr_setup_lo) begin
            if (!reg_wdata_i[0]) begin
                setup_r.channel_go <= 1'b0; // [RULE_18]
            end else if (!summary) begin
                setup_r.channel_go <= 1'b1; // [RULE_19]
            end
        end
    end

    // ------------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------------
    // enabling breakpoint interrupts by write also raises the breakpoint flag
    assign flag_set.done = done_evt_i && !flags_r.done;
    assign flag_set.read_fault = read_fault_evt_i && !flags_r.read_fault;
    assign flag_set.write_fault = write_fault_evt_i && !flags_r.write_fault;
    assign flag_set.setup_fault = setup_fault_evt_i && !flags_r.setup_fault;
    assign flag_set.breakpoint = (breakpoint_evt_i || (wr_setup_hi && reg_wdata_i[15]))
                                 && !flags_r.breakpoint; // [RULE_05]
    assign summary = |flags_r; // [RULE_24]

    generate
        for (genvar i = 0; i < 5; i++) begin : g_flag
            always_ff @(posedge clk_i) begin
                if (!rst_b_i) begin
                    flags_r[i] <= 1'b0;
                end else if (flag_set[i]) begin
                    flags_r[i] <= 1'b1;
                end else if (wr_state_hi && reg_wdata_i[dmc_pkg::STATE_BRK_BIT + i]) begin
                    flags_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            irq_req_o <= 1'b0;
            irq_level_o <= 3'h0;
            irq_vector_o <= dmc_pkg::VECTOR_RESET;
        end else begin
            irq_req_o <= (setup_r.breakpoint_irq_enable && flags_r.breakpoint) // [RULE_05]
                      || (setup_r.done_irq_enable && flags_r.done) // [RULE_06]
                      || (setup_r.error_irq_enable && (flags_r.read_fault
                          || flags_r.write_fault || flags_r.setup_fault)); // [RULE_07]
            irq_level_o <= level_r; // [RULE_02]
            irq_vector_o <= vector_r; // [RULE_03]
        end
    end

    // ------------------------------------------------------------------
    // external demand synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            demand_meta_r <= 1'b0;
            demand_sync_r <= 1'b0;
        end else begin
            demand_meta_r <= ext_transfer_demand_i;
            demand_sync_r <= demand_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // channel state
    // ------------------------------------------------------------------
    // reserved trigger code is neither internal nor external: channel stays idle
    assign ext_mode = setup_r.transfer_trigger[1]; // [RULE_15]

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            dmc_pkg::CH_IDLE: begin
                if (setup_r.channel_go && !summary && !(|flag_set)) begin // [RULE_19]
                    if (ext_mode) begin
                        state_nxt = dmc_pkg::CH_ARMED; // [RULE_21]
                    end else if (setup_r.transfer_trigger == dmc_pkg::TRIG_INTERNAL) begin
                        state_nxt = dmc_pkg::CH_RUN; // [RULE_20]
                    end
                end
            end
            dmc_pkg::CH_ARMED: begin
                if (demand_sync_r) begin
                    state_nxt = dmc_pkg::CH_RUN; // [RULE_21]
                end
            end
            dmc_pkg::CH_RUN: begin
                // switching to the reserved code mid-run stops requests at once
                if (setup_r.transfer_trigger == dmc_pkg::TRIG_RESERVED) begin
                    state_nxt = dmc_pkg::CH_IDLE; // [RULE_15] [RULE_22]
                end else if (setup_r.transfer_trigger == dmc_pkg::TRIG_EXT_BURST
                             && !demand_sync_r) begin
                    state_nxt = dmc_pkg::CH_ARMED;
                end
            end
            default: state_nxt = dmc_pkg::CH_IDLE;
        endcase
        // go low stops the channel whatever the mode
        if (!setup_r.channel_go) begin
            state_nxt = dmc_pkg::CH_IDLE; // [RULE_20] [RULE_21]
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_r <= dmc_pkg::CH_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // bandwidth window
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            bw_cnt_r <= '0;
        end else begin
            bw_cnt_r <= bw_cnt_r + 1'b1;
        end
    end

    // share n+1 quarters: the window's upper two bits must not pass the field
    assign bw_open = (bw_cnt_r[dmc_pkg::BW_CNT_W-1 -: 2] <= setup_r.bandwidth_share); // [RULE_16]

    // ------------------------------------------------------------------
    // transfer engine controls
    // ------------------------------------------------------------------
    always_comb begin
        case (setup_r.read_width_select) // [RULE_13]
            dmc_pkg::WIDTH_LONG: src_size_step = dmc_pkg::STEP_LONG;
            dmc_pkg::WIDTH_BYTE: src_size_step = dmc_pkg::STEP_BYTE;
            dmc_pkg::WIDTH_WORD: src_size_step = dmc_pkg::STEP_WORD;
            default: src_size_step = dmc_pkg::STEP_NONE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            bus_request_o <= 1'b0;
            ext_transfer_grant_o <= 1'b0;
            hs_read_phase_o <= 1'b0;
            single_address_o <= 1'b0;
            dst_hold_used_o <= 1'b0;
            read_width_o <= dmc_pkg::WIDTH_LONG;
            write_width_o <= dmc_pkg::WIDTH_LONG;
            src_step_o <= dmc_pkg::STEP_NONE;
            dst_step_o <= dmc_pkg::STEP_NONE;
        end else begin
            bus_request_o <= (state_nxt == dmc_pkg::CH_RUN)
                          && (ext_mode || bw_open); // [RULE_16] [RULE_20] [RULE_21]
            ext_transfer_grant_o <= (state_nxt == dmc_pkg::CH_RUN) && ext_mode;
            // option selects read phase (single) or source requester (dual)
            hs_read_phase_o <= ext_mode
                            && setup_r.external_handshake_option; // [RULE_08] [RULE_09] [RULE_10]
            single_address_o <= setup_r.single_address; // [RULE_17]
            dst_hold_used_o <= !setup_r.single_address; // [RULE_17]
            read_width_o <= setup_r.read_width_select; // [RULE_13]
            write_width_o <= setup_r.write_width_select; // [RULE_14]
            src_step_o <= setup_r.src_pointer_step ? src_size_step
                                                   : dmc_pkg::STEP_NONE; // [RULE_11]
            dst_step_o <= setup_r.dst_pointer_step ? src_size_step
                                                   : dmc_pkg::STEP_NONE; // [RULE_12]
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_arm;
        state_r == dmc_pkg::CH_ARMED && setup_r.channel_go;
    endsequence
    sequence s_demand;
        demand_sync_r ##1 state_r == dmc_pkg::CH_RUN;
    endsequence

    halt_berr_a: assert property (reg_sel_i && module_halt_bit_i |=> reg_berr_o && !reg_ack_o)
        else $error("halted access not answered with bus error"); // [RULE_23]
    user_irq_a: assert property (acc_irq && !reg_sup_i && reg_wr_i |=> $stable(vector_r))
        else $error("user write changed irq setup"); // [RULE_01]
    flag_stop_a: assert property (|flag_set |=> !setup_r.channel_go ##1 state_r == dmc_pkg::CH_IDLE)
        else $error("new flag did not stop channel"); // [RULE_18]
    go_block_a: assert property (summary && !setup_r.channel_go |=> !setup_r.channel_go)
        else $error("go set while summary flag set"); // [RULE_19]
    summary_or_a: assert property (reg_sel_i && acc_ok && acc_state && !reg_wr_i
                                   |=> reg_rdata_o[15] == (|reg_rdata_o[14:10]))
        else $error("summary bit not or of flags"); // [RULE_24]
    done_irq_a: assert property (setup_r.done_irq_enable && flags_r.done |=> irq_req_o)
        else $error("done interrupt missing"); // [RULE_06]
    brk_write_a: assert property (wr_setup_hi && reg_wdata_i[15] |=> flags_r.breakpoint)
        else $error("breakpoint enable did not raise flag"); // [RULE_05]
    ext_start_a: assert property (s_arm ##0 demand_sync_r |=> state_r == dmc_pkg::CH_RUN)
        else $error("armed channel ignored demand"); // [RULE_21]
    int_start_a: assert property (state_r != dmc_pkg::CH_ARMED && setup_r.channel_go
                                  && !(|flag_set) && setup_r.transfer_trigger == dmc_pkg::TRIG_INTERNAL
                                  |=> state_r == dmc_pkg::CH_RUN)
        else $error("internal channel stopped with go set"); // [RULE_20]
    bw_limit_a: assert property (!ext_mode && !bw_open |=> !bus_request_o)
        else $error("bandwidth share exceeded"); // [RULE_16]
    ext_grant_a: assert property (s_demand |-> ##[0:1] ext_transfer_grant_o || !ext_mode)
        else $error("grant not raised for demand"); // [RULE_21]

endmodule : dmc_channel

// [verif/dmc_ext_peer.sv]
// far-side peripheral model driving the transfer demand pin
`timescale 1ns/1ps
module dmc_ext_peer (
    // clock
    input wire logic clk_i,
    // bench command
    input wire logic want_i,
    // demand pin
    output logic ext_transfer_demand_o
);
    initial ext_transfer_demand_o = 1'b0;
    // demand is held until withdrawn; the pin is synchronised inside, so no edge is owed
    always @(negedge clk_i) begin
        ext_transfer_demand_o <= want_i;
    end
endmodule : dmc_ext_peer

// [verif/testbench.sv]
// self-checking bench for the dma channel setup and interrupt block
`timescale 1ns/1ps
module testbench;
    // ------------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------------
    logic clk_i = 1'b0, rst_b_i = 1'b0, sel = 1'b0, wr = 1'b0, sup = 1'b1, halt = 1'b0;
    logic want = 1'b0, ack, berr, grant, demand, breq, hsr, sgl, hold, irq, a, b;
    logic [11:0] addr = 12'h000;
    logic [1:0] be = 2'h3, rw, ww;
    logic [15:0] wdata = 16'h0000, rdata, rd, v;
    logic [4:0] evt = 5'h00;
    logic [2:0] ss, ds, lvl;
    logic [7:0] vec;
    int n_errors = 0, checked = 0, cyc = 0, i;

    dmc_channel dut_u (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_sel_i(sel), .reg_wr_i(wr),
        .reg_addr_i(addr), .reg_be_i(be), .reg_sup_i(sup), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .reg_ack_o(ack), .reg_berr_o(berr), .module_halt_bit_i(halt),
        .done_evt_i(evt[4]), .read_fault_evt_i(evt[3]), .write_fault_evt_i(evt[2]),
        .setup_fault_evt_i(evt[1]), .breakpoint_evt_i(evt[0]),
        .ext_transfer_demand_i(demand), .ext_transfer_grant_o(grant),
        .bus_request_o(breq), .hs_read_phase_o(hsr), .single_address_o(sgl),
        .dst_hold_used_o(hold), .read_width_o(rw), .write_width_o(ww),
        .src_step_o(ss), .dst_step_o(ds), .irq_req_o(irq), .irq_level_o(lvl),
        .irq_vector_o(vec)
    );
    dmc_ext_peer peer_u (.clk_i(clk_i), .want_i(want), .ext_transfer_demand_o(demand));

    initial forever #12.5 clk_i = ~clk_i;

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            summarize();
        end
    end
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask : chk

    // strobe is one cycle wide; the answer lands one edge after it is taken
    task automatic acc(input logic w, input logic [11:0] ad, input logic [15:0] d);
        @(negedge clk_i);
        {sel, wr, addr, wdata} = {1'b1, w, ad, d};
        @(negedge clk_i);
        {rd, a, b} = {rdata, ack, berr};
        sel = 1'b0;
    endtask : acc

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_i);
    endtask : wait_n

    task automatic pulse(input logic [4:0] e);
        @(negedge clk_i);
        evt = e;
        @(negedge clk_i);
        evt = 5'h00;
        wait_n(3);
    endtask : pulse

    // flags clear by writing ones to the high byte of the state register
    task automatic clr();
        be = 2'h2;
        acc(1'b1, dmc_pkg::CHANNEL_STATE_OFS, 16'h7c00);
        be = 2'h3;
        wait_n(2);
    endtask : clr

    function automatic logic [2:0] step(input logic [1:0] sz, input logic en);
        if (!en || sz == 2'h3) return 3'h0;
        return (sz == 2'h0) ? 3'h4 : {1'b0, sz};
    endfunction : step

    initial begin
        v = $urandom(7);
        repeat (10) @(negedge clk_i);
        rst_b_i = 1'b1;
        chk({lvl, vec}, 11'h00f);
        acc(1'b0, dmc_pkg::IRQ_SETUP_OFS, 16'h0);
        chk({a, b, rd}, {2'b10, 16'h000f});
        acc(1'b0, dmc_pkg::CHANNEL_SETUP_OFS, 16'h0);
        chk(rd[0], 1'b0);
        sup = 1'b0;
        acc(1'b0, dmc_pkg::IRQ_SETUP_OFS, 16'h0);
        chk({a, b}, 2'b01);
        halt = 1'b1;
        acc(1'b0, dmc_pkg::CHANNEL_SETUP_OFS, 16'h0);
        chk({a, b}, 2'b01);
        {halt, sup} = 2'b01;
        v = $urandom & 16'h07ff;
        acc(1'b1, dmc_pkg::IRQ_SETUP_OFS, v);
        acc(1'b0, dmc_pkg::IRQ_SETUP_OFS, 16'h0);
        chk({a, rd, lvl, vec}, {1'b1, v, v[10:0]});
        sup = 1'b0;
        for (i = 0; i < 10; i++) begin
            v = (i == 0) ? 16'h0f00 : (i == 1) ? 16'h0c00 : ($urandom & 16'h7ffe);
            acc(1'b1, dmc_pkg::CHANNEL_SETUP_OFS, v);
            acc(1'b0, dmc_pkg::CHANNEL_SETUP_OFS, 16'h0);
            chk({a, b, rd}, {2'b10, v});
            chk({rw, ww, sgl, hold}, {v[9:6], v[1], ~v[1]});
            chk({ss, ds}, {step(v[9:8], v[11]), step(v[9:8], v[10])});
        end
        sup = 1'b1;
        acc(1'b1, dmc_pkg::CHANNEL_SETUP_OFS, 16'h500d);
        wait_n(2);
        chk({breq, grant, hsr}, 3'b100);
        acc(1'b1, dmc_pkg::CHANNEL_SETUP_OFS, 16'h500c);
        wait_n(2);
        chk(breq, 1'b0);
        acc(1'b1, dmc_pkg::CHANNEL_SETUP_OFS, 16'h500d);
        pulse(5'h10);
        chk({irq, breq}, 2'b10);
        acc(1'b0, dmc_pkg::CHANNEL_STATE_OFS, 16'h0);
        chk(rd, 16'hc000);
        acc(1'b1, dmc_pkg::CHANNEL_SETUP_OFS, 16'h500d);
        acc(1'b0, dmc_pkg::CHANNEL_SETUP_OFS, 16'h0);
        chk(rd[0], 1'b0);
        clr();
        chk(irq, 1'b0);
        for (i = 1; i < 5; i++) begin
            acc(1'b1, dmc_pkg::CHANNEL_SETUP_OFS, 16'h200d);
            pulse(5'h01 << i);
            acc(1'b0, dmc_pkg::CHANNEL_STATE_OFS, 16'h0);
            chk({irq, rd[15:10]}, {(i != 4), 1'b1, 5'h01 << i});
            clr();
        end
        acc(1'b1, dmc_pkg::CHANNEL_SETUP_OFS, 16'h800c);
        acc(1'b0, dmc_pkg::CHANNEL_STATE_OFS, 16'h0);
        wait_n(1);
        chk({irq, rd[15:10]}, 7'h61);
        acc(1'b1, dmc_pkg::CHANNEL_SETUP_OFS, 16'h000c);
        clr();
        acc(1'b1, dmc_pkg::CHANNEL_SETUP_OFS, 16'h1021);
        wait_n(4);
        chk({grant, breq}, 2'b00);
        want = 1'b1;
        wait_n(6);
        chk({grant, hsr}, 2'b11);
        want = 1'b0;
        wait_n(6);
        chk(grant, 1'b0);
        acc(1'b1, dmc_pkg::CHANNEL_SETUP_OFS, 16'h0023);
        want = 1'b1;
        wait_n(6);
        chk({grant, hsr, sgl}, 3'b101);
        acc(1'b1, dmc_pkg::CHANNEL_SETUP_OFS, 16'h0022);
        wait_n(3);
        chk(grant, 1'b0);
        acc(1'b1, dmc_pkg::CHANNEL_SETUP_OFS, 16'h1033);
        wait_n(6);
        chk({grant, hsr}, 2'b11);
        want = 1'b0;
        wait_n(6);
        chk(grant, 1'b1);
        acc(1'b1, dmc_pkg::CHANNEL_SETUP_OFS, 16'h0011);
        want = 1'b1;
        wait_n(6);
        chk({grant, breq}, 2'b00);
        summarize();
    end
endmodule : testbench
